/* File: rtl/exec_params.svh */
// constants for the add-immediate and converter-start execution block
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
`define MODE_SEL_POS 3
`define ACC_RESET 4'h0
`define CARRY_RESET 1'b0
`define DONE_RESET 1'b0
`define CTRL_RESET 4'h0
`define OP_CYCLES 1
`endif

/* File: rtl/exec_pkg.sv */
// types shared by the execution block
package exec_pkg;
	typedef logic [3:0] nibble_t;
	typedef enum logic [3:0] {
		OP_NONE = 4'h1,
		OP_ADD_IMM = 4'h2,
		OP_CONV_START = 4'h4,
		OP_SKIP_DONE = 4'h8
	} op_e;
endpackage : exec_pkg

/* File: rtl/imm_adder.sv */
// 4-bit immediate adder with carry out
`timescale 1ns/1ps
module imm_adder (
	input wire exec_pkg::nibble_t a,
	input wire exec_pkg::nibble_t b,
	output exec_pkg::nibble_t sum,
	output logic carry_out
);
	import exec_pkg::*;
	logic [4:0] full;
	assign full = {1'b0, a} + {1'b0, b};
	assign sum = full[3:0];
	assign carry_out = full[4];
endmodule : imm_adder

/* File: rtl/exec_unit.sv */
// execution of add-immediate, converter start and converter-done skip test
`timescale 1ns/1ps
`include "exec_params.svh"
module exec_unit (
	input wire logic clk,
	input wire logic rst_n,
	input wire exec_pkg::op_e op,
	input wire exec_pkg::nibble_t imm,
	input wire logic ctrl_we,
	input wire exec_pkg::nibble_t ctrl_wdata,
	input wire logic carry_we,
	input wire logic carry_wdata,
	input wire logic converter_irq_enable_bit,
	input wire logic conversion_end,
	output exec_pkg::nibble_t acc,
	output logic carry_flag,
	output logic conversion_done_flag,
	output exec_pkg::nibble_t converter_control_reg,
	output logic skip_next,
	output logic conversion_start,
	output logic comparator_start
);
	import exec_pkg::*;

	// ----------------------------------------
	// datapath
	// ----------------------------------------
	nibble_t sum;
	logic ovf;
	logic mode_sel;
	logic done_skip;

	imm_adder u_add (
		.a(acc),
		.b(imm),
		.sum(sum),
		.carry_out(ovf)
	);

	assign mode_sel = converter_control_reg[`MODE_SEL_POS];
	assign done_skip = (op == OP_SKIP_DONE) && !converter_irq_enable_bit && conversion_done_flag;

	// ----------------------------------------
	// architectural state
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc <= `ACC_RESET;
		end else if (op == OP_ADD_IMM) begin
			acc <= sum;
		end
	end

	// carry only changes through its own write port
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			carry_flag <= `CARRY_RESET;
		end else if (carry_we) begin
			carry_flag <= carry_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			converter_control_reg <= `CTRL_RESET;
		end else if (ctrl_we) begin
			converter_control_reg <= ctrl_wdata;
		end
	end

	// the instruction's clear wins over a simultaneous converter end,
	// since the start begins a new conversion whose end is still ahead
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conversion_done_flag <= `DONE_RESET;
		end else if (op == OP_CONV_START) begin
			conversion_done_flag <= 1'b0;
		end else if (conversion_end) begin
			conversion_done_flag <= 1'b1;
		end else if (done_skip) begin
			conversion_done_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// one-cycle results
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			skip_next <= 1'b0;
		end else begin
			skip_next <= ((op == OP_ADD_IMM) && !ovf) || done_skip;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conversion_start <= 1'b0;
			comparator_start <= 1'b0;
		end else begin
			conversion_start <= (op == OP_CONV_START) && !mode_sel;
			comparator_start <= (op == OP_CONV_START) && mode_sel;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_add_no_ovf;
		(op == OP_ADD_IMM) && ({1'b0, acc} + {1'b0, imm} < 5'h10);
	endsequence

	property p_add_sum;
		@(posedge clk) disable iff (!rst_n)
		(op == OP_ADD_IMM) |=> acc == 4'($past(acc) + $past(imm));
	endproperty
	a_add_sum: assert property (p_add_sum) else $error("accumulator sum wrong");

	property p_carry_kept;
		@(posedge clk) disable iff (!rst_n)
		(op == OP_ADD_IMM) && !carry_we |=> $stable(carry_flag);
	endproperty
	a_carry_kept: assert property (p_carry_kept) else $error("carry changed by add");

	property p_skip_no_ovf;
		@(posedge clk) disable iff (!rst_n)
		s_add_no_ovf |=> skip_next;
	endproperty
	a_skip_no_ovf: assert property (p_skip_no_ovf) else $error("no skip without overflow");

	property p_no_skip_ovf;
		@(posedge clk) disable iff (!rst_n)
		(op == OP_ADD_IMM) && ovf |=> !skip_next;
	endproperty
	a_no_skip_ovf: assert property (p_no_skip_ovf) else $error("skip on overflow");

	property p_start_clears;
		@(posedge clk) disable iff (!rst_n)
		(op == OP_CONV_START) |=> !conversion_done_flag;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("done flag not cleared");

	property p_conv_start;
		@(posedge clk) disable iff (!rst_n)
		(op == OP_CONV_START) && !converter_control_reg[`MODE_SEL_POS] |=> conversion_start && !comparator_start;
	endproperty
	a_conv_start: assert property (p_conv_start) else $error("conversion not started");

	property p_cmp_start;
		@(posedge clk) disable iff (!rst_n)
		(op == OP_CONV_START) && converter_control_reg[`MODE_SEL_POS] |=> comparator_start && !conversion_start;
	endproperty
	a_cmp_start: assert property (p_cmp_start) else $error("comparator not started");

	property p_done_skip;
		@(posedge clk) disable iff (!rst_n)
		(op == OP_SKIP_DONE) && !converter_irq_enable_bit && conversion_done_flag && !conversion_end
		|=> skip_next && !conversion_done_flag;
	endproperty
	a_done_skip: assert property (p_done_skip) else $error("done skip wrong");

	property p_done_nop;
		@(posedge clk) disable iff (!rst_n)
		(op == OP_SKIP_DONE) && converter_irq_enable_bit |=> !skip_next && $stable(acc)
			&& (conversion_done_flag == ($past(conversion_done_flag) || $past(conversion_end)));
	endproperty
	a_done_nop: assert property (p_done_nop) else $error("disabled skip test acted");

	// ----------------------------------------
	// held state and quiet outputs
	// ----------------------------------------
	// a converter end only counts when no start clears the flag in the same cycle
	sequence s_end_alone;
		conversion_end && (op != OP_CONV_START);
	endsequence

	// the flag may only move on a start, a converter end or an enabled skip test
	sequence s_flag_untouched;
		(op != OP_CONV_START) && !conversion_end
			&& !((op == OP_SKIP_DONE) && !converter_irq_enable_bit);
	endsequence

	property p_end_sets;
		@(posedge clk) disable iff (!rst_n)
		s_end_alone |=> conversion_done_flag;
	endproperty
	a_end_sets: assert property (p_end_sets) else $error("converter end did not set done flag");

	property p_flag_held;
		@(posedge clk) disable iff (!rst_n)
		s_flag_untouched |=> $stable(conversion_done_flag);
	endproperty
	a_flag_held: assert property (p_flag_held) else $error("done flag moved without cause");

	property p_acc_held;
		@(posedge clk) disable iff (!rst_n)
		(op != OP_ADD_IMM) |=> $stable(acc);
	endproperty
	a_acc_held: assert property (p_acc_held) else $error("accumulator moved without add");

	property p_carry_write;
		@(posedge clk) disable iff (!rst_n)
		carry_we |=> carry_flag == $past(carry_wdata);
	endproperty
	a_carry_write: assert property (p_carry_write) else $error("carry write lost");

	property p_ctrl_write;
		@(posedge clk) disable iff (!rst_n)
		ctrl_we |=> converter_control_reg == $past(ctrl_wdata);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_ctrl_held;
		@(posedge clk) disable iff (!rst_n)
		!ctrl_we |=> $stable(converter_control_reg);
	endproperty
	a_ctrl_held: assert property (p_ctrl_held) else $error("control register moved without write");

	property p_skip_quiet;
		@(posedge clk) disable iff (!rst_n)
		(op != OP_ADD_IMM) && (op != OP_SKIP_DONE) |=> !skip_next;
	endproperty
	a_skip_quiet: assert property (p_skip_quiet) else $error("skip without a skipping op");

	property p_starts_quiet;
		@(posedge clk) disable iff (!rst_n)
		(op != OP_CONV_START) |=> !conversion_start && !comparator_start;
	endproperty
	a_starts_quiet: assert property (p_starts_quiet) else $error("start pulse without start op");

	// sync reset: every register is at its reset value one edge later,
	// whatever op or side input stood beside the reset
	property p_reset_clears;
		@(posedge clk)
		!rst_n |=> (acc == `ACC_RESET)
			&& (carry_flag == `CARRY_RESET)
			&& (conversion_done_flag == `DONE_RESET)
			&& (converter_control_reg == `CTRL_RESET)
			&& !skip_next && !conversion_start && !comparator_start;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("register not cleared by reset");
endmodule : exec_unit

/* File: test/exec_unit_tb.sv */
// self-checking bench for the execution block
`timescale 1ns/1ps
module exec_unit_tb;
	import exec_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	op_e op = OP_NONE;
	nibble_t imm = 4'h0;
	logic ctrl_we = 1'b0;
	nibble_t ctrl_wdata = 4'h0;
	logic carry_we = 1'b0;
	logic carry_wdata = 1'b1;
	logic converter_irq_enable_bit = 1'b0;
	logic conversion_end = 1'b0;
	nibble_t acc, converter_control_reg;
	logic carry_flag, conversion_done_flag, skip_next, conversion_start, comparator_start;
	int err_total = 0;
	int check_count = 0;
	// rows: immediate, accumulator after, skip expected; the 4-bit wrap is the overflow case
	logic [8:0] rows [6] = '{{4'h3, 4'h3, 1'b1}, {4'hc, 4'hf, 1'b1}, {4'h1, 4'h0, 1'b0},
		{4'hf, 4'hf, 1'b1}, {4'hf, 4'he, 1'b0}, {4'h0, 4'he, 1'b1}};
	exec_unit i_dut (.clk, .rst_n, .op, .imm, .ctrl_we, .ctrl_wdata, .carry_we, .carry_wdata,
		.converter_irq_enable_bit, .conversion_end, .acc, .carry_flag, .conversion_done_flag,
		.converter_control_reg, .skip_next, .conversion_start, .comparator_start);
	always #5 clk = ~clk;
	task chk(logic [15:0] seen, logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// side bits: control write, carry write, converter end
	task cyc(op_e o, nibble_t i, logic [2:0] side);
		@(negedge clk);
		op = o;
		imm = i;
		ctrl_wdata = i;
		{ctrl_we, carry_we, conversion_end} = side;
		@(posedge clk);
		#1;
		@(negedge clk);
		op = OP_NONE;
		{ctrl_we, carry_we, conversion_end} = 3'b000;
		#4;
	endtask : cyc
	task end_of_test;
		if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		chk({acc, carry_flag, conversion_done_flag, converter_control_reg, skip_next, conversion_start,
			comparator_start}, 16'h0000);
		cyc(OP_NONE, 4'h0, 3'b010);
		foreach (rows[k]) begin
			cyc(OP_ADD_IMM, rows[k][8:5], 3'b000);
			chk(acc, rows[k][4:1]);
			chk(skip_next, rows[k][0]);
			chk(carry_flag, 1'b1);
		end
		cyc(OP_NONE, 4'h0, 3'b001);
		cyc(OP_CONV_START, 4'h0, 3'b000);
		chk({conversion_start, comparator_start, conversion_done_flag}, 3'b100);
		cyc(OP_NONE, 4'h0, 3'b000);
		chk({conversion_start, comparator_start}, 2'b00);
		cyc(OP_NONE, 4'h8, 3'b101);
		chk(converter_control_reg, 4'h8);
		cyc(OP_CONV_START, 4'h0, 3'b000);
		chk({conversion_start, comparator_start, conversion_done_flag}, 3'b010);
		cyc(OP_NONE, 4'h0, 3'b000);
		chk({conversion_start, comparator_start}, 2'b00);
		// start beside a converter end, mode bit set: the comparator start leaves the flag clear
		cyc(OP_CONV_START, 4'h0, 3'b001);
		chk({conversion_start, comparator_start, conversion_done_flag}, 3'b010);
		// low control bits set, mode bit clear: still a conversion
		cyc(OP_NONE, 4'h7, 3'b100);
		cyc(OP_CONV_START, 4'h0, 3'b000);
		chk({conversion_start, comparator_start, converter_control_reg}, 6'h27);
		@(negedge clk);
		converter_irq_enable_bit = 1'b1;
		cyc(OP_SKIP_DONE, 4'h0, 3'b001);
		cyc(OP_SKIP_DONE, 4'h0, 3'b000);
		chk({skip_next, conversion_done_flag}, 2'b01);
		@(negedge clk);
		converter_irq_enable_bit = 1'b0;
		cyc(OP_SKIP_DONE, 4'h0, 3'b000);
		chk({skip_next, conversion_done_flag}, 2'b10);
		cyc(OP_SKIP_DONE, 4'h0, 3'b000);
		chk(skip_next, 1'b0);
		// converter end beside the skip test: the set wins, the skip still happens
		cyc(OP_NONE, 4'h0, 3'b001);
		cyc(OP_SKIP_DONE, 4'h0, 3'b001);
		chk({skip_next, conversion_done_flag}, 2'b11);
		// carry held low through an overflowing add
		@(negedge clk);
		carry_wdata = 1'b0;
		cyc(OP_NONE, 4'h0, 3'b010);
		cyc(OP_ADD_IMM, 4'hf, 3'b000);
		chk({acc, skip_next, carry_flag}, 6'h34);
		// mid-run reset with all three side bits set and the skip-test enable low, then a clean restart
		@(negedge clk);
		rst_n = 1'b0;
		cyc(OP_ADD_IMM, 4'h3, 3'b111);
		chk({acc, carry_flag, conversion_done_flag, converter_control_reg, skip_next, conversion_start,
			comparator_start}, 16'h0000);
		@(negedge clk);
		rst_n = 1'b1;
		cyc(OP_ADD_IMM, 4'h5, 3'b000);
		chk({acc, skip_next, carry_flag}, 6'h16);
		end_of_test();
	end
endmodule : exec_unit_tb
